// File: core/sfrec_pkg.sv
package sfrec_pkg;
    localparam logic [7:0] SFREC_STX = 8'h02;
    localparam logic [7:0] SFREC_ETX = 8'h03;
    localparam logic [7:0] SFREC_DLE = 8'h10;
    localparam logic [7:0] SFREC_NAK = 8'h15;
    localparam logic [7:0] SFREC_CLASS_RX = 8'h08;
    localparam logic [7:0] SFREC_EV_REPEAT = 8'h01;
    localparam logic [7:0] SFREC_EV_SETUP  = 8'h02;
    localparam logic [7:0] SFREC_EV_LOGIC  = 8'h05;
    localparam logic [7:0] SFREC_EV_CHDLY  = 8'h06;
    localparam logic [7:0] SFREC_EV_BCC    = 8'h08;
    localparam logic [7:0] SFREC_EV_NOBUF  = 8'h0a;
    localparam logic [7:0] SFREC_EV_TXERR  = 8'h0c;
    localparam logic [7:0] SFREC_EV_NONE   = 8'h00;
    localparam int SFREC_CLK_MHZ   = 250;
    localparam int SFREC_CHDLY_US  = 220;
    localparam int SFREC_BUFWT_US  = 400;
    localparam int SFREC_CHDLY_CYC = SFREC_CHDLY_US * SFREC_CLK_MHZ;
    localparam int SFREC_BUFWT_CYC = SFREC_BUFWT_US * SFREC_CLK_MHZ;
    localparam int SFREC_MAX_REP   = 6;
    localparam int SFREC_TW        = 20;
endpackage : sfrec_pkg

// File: core/sfrec_timer.sv
`timescale 1ns/100ps
`default_nettype none
module sfrec_timer #(
    parameter int TW = 20
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          restart,
    input  wire logic          run,
    input  wire logic [TW-1:0] limit,
    output logic               expired
);
    logic [TW-1:0] cnt_r;

    // a restart always reloads, so a stale count never leaks into a new wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= '0;
            expired <= 1'b0;
        end else if (restart || !run) begin
            cnt_r   <= '0;
            expired <= 1'b0;
        end else begin
            expired <= (cnt_r == limit - TW'(1));
            if (cnt_r != limit)
                cnt_r <= cnt_r + TW'(1);
        end
    end
endmodule : sfrec_timer
`default_nettype wire

// File: core/sfrec_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sfrec_checker
    import sfrec_pkg::*;
#(
    parameter int CHDLY_CYC = SFREC_CHDLY_CYC,
    parameter int BUFWT_CYC = SFREC_BUFWT_CYC,
    parameter int MAX_REP   = SFREC_MAX_REP
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_fault,
    input  wire logic       bcc_en,
    input  wire logic       buf_free,
    input  wire logic       partner_startup,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            ev_valid,
    output logic [7:0]      ev_class,
    output logic [7:0]      ev_number,
    output logic            frame_done,
    output logic [3:0]      rep_count
);
    import sfrec_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_WBUF = 5'b00010,
        S_DATA = 5'b00100,
        S_ESC  = 5'b01000,
        S_BCC  = 5'b10000
    } sfrec_state_t;

    localparam logic [SFREC_TW-1:0] CHDLY_L = SFREC_TW'(CHDLY_CYC);
    localparam logic [SFREC_TW-1:0] BUFWT_L = SFREC_TW'(BUFWT_CYC);

    logic         rst_s1_r;
    logic         rst_n_r;
    sfrec_state_t state_r;
    logic [7:0]   bcc_r;
    logic [7:0]   first_err_r;
    logic         ch_to;
    logic         buf_to;
    logic         ch_run;
    logic [3:0]   rep_max;
    logic [7:0]   cur_err;

    assign rep_max = 4'(MAX_REP);

    // classify this cycle's error; a timeout outranks a late character
    always_comb begin
        if (ch_to)
            cur_err = SFREC_EV_CHDLY;
        else if (rx_fault)
            cur_err = SFREC_EV_TXERR;
        else if (state_r == S_ESC)
            cur_err = SFREC_EV_LOGIC;
        else
            cur_err = SFREC_EV_BCC;
    end

    // reset released through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    assign ch_run = (state_r == S_DATA) || (state_r == S_ESC)
                 || (state_r == S_BCC);

    sfrec_timer #(.TW(SFREC_TW)) u_chdly (
        .clk     (clk),
        .rst_n   (rst_n_r),
        .restart (rx_valid),
        .run     (ch_run),
        .limit   (CHDLY_L),
        .expired (ch_to)
    );

    sfrec_timer #(.TW(SFREC_TW)) u_bufwt (
        .clk     (clk),
        .rst_n   (rst_n_r),
        .restart (1'b0),
        .run     (state_r == S_WBUF),
        .limit   (BUFWT_L),
        .expired (buf_to)
    );

    // receive state machine with error classification
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r     <= S_IDLE;
            bcc_r       <= 8'h00;
            first_err_r <= SFREC_EV_NONE;
            rep_count   <= 4'h0;
            tx_valid    <= 1'b0;
            tx_data     <= 8'h00;
            ev_valid    <= 1'b0;
            ev_class    <= SFREC_CLASS_RX;
            ev_number   <= SFREC_EV_NONE;
            frame_done  <= 1'b0;
        end else begin
            tx_valid   <= 1'b0;
            ev_valid   <= 1'b0;
            frame_done <= 1'b0;
            ev_class   <= SFREC_CLASS_RX;
            unique case (state_r)
                S_IDLE: begin
                    if (rx_valid && rx_fault) begin
                        ev_valid  <= 1'b1;
                        ev_number <= SFREC_EV_TXERR;
                    end else if (rx_valid && rx_data == SFREC_STX) begin
                        bcc_r <= 8'h00;
                        if (buf_free) begin
                            tx_valid <= 1'b1;
                            tx_data  <= SFREC_DLE;
                            state_r  <= S_DATA;
                        end else begin
                            state_r <= S_WBUF;
                        end
                    end else if (rx_valid && rx_data != SFREC_NAK) begin
                        // covers power-up garbage from the partner too, other than a NAK
                        ev_valid  <= 1'b1;
                        ev_number <= SFREC_EV_SETUP;
                    end else if (partner_startup && rx_valid) begin
                        ev_valid  <= 1'b1;
                        ev_number <= SFREC_EV_SETUP;
                    end
                end
                S_WBUF: begin
                    if (rx_valid) begin
                        ev_valid  <= 1'b1;
                        ev_number <= SFREC_EV_SETUP;
                        state_r   <= S_IDLE;
                    end else if (buf_free) begin
                        tx_valid <= 1'b1;
                        tx_data  <= SFREC_DLE;
                        state_r  <= S_DATA;
                    end else if (buf_to) begin
                        ev_valid  <= 1'b1;
                        ev_number <= SFREC_EV_NOBUF;
                        state_r   <= S_IDLE;
                    end
                end
                S_DATA, S_ESC, S_BCC: begin
                    if (ch_to || (rx_valid && rx_fault)
                        || (state_r == S_ESC && rx_valid && !rx_fault
                            && rx_data != SFREC_DLE
                            && rx_data != SFREC_ETX)
                        || (state_r == S_BCC && rx_valid && !rx_fault
                            && rx_data != bcc_r)) begin
                        // keep only the first error of a retry sequence
                        if (first_err_r == SFREC_EV_NONE)
                            first_err_r <= cur_err;
                        state_r <= S_IDLE;
                        if (rep_count >= rep_max) begin
                            ev_valid    <= 1'b1;
                            ev_number   <= (first_err_r == SFREC_EV_NONE)
                                ? cur_err : first_err_r;
                            rep_count   <= 4'h0;
                            first_err_r <= SFREC_EV_NONE;
                        end else begin
                            tx_valid  <= 1'b1;
                            tx_data   <= SFREC_NAK;
                            rep_count <= rep_count + 4'h1;
                            if (rep_count == 4'h0) begin
                                ev_valid  <= 1'b1;
                                ev_number <= SFREC_EV_REPEAT;
                            end
                        end
                    end else if (rx_valid) begin
                        bcc_r <= bcc_r ^ rx_data;
                        if (state_r == S_DATA) begin
                            if (rx_data == SFREC_DLE)
                                state_r <= S_ESC;
                        end else if (state_r == S_ESC) begin
                            if (rx_data == SFREC_ETX && bcc_en) begin
                                state_r <= S_BCC;
                            end else if (rx_data == SFREC_ETX) begin
                                tx_valid    <= 1'b1;
                                tx_data     <= SFREC_DLE;
                                frame_done  <= 1'b1;
                                rep_count   <= 4'h0;
                                first_err_r <= SFREC_EV_NONE;
                                state_r     <= S_IDLE;
                            end else begin
                                state_r <= S_DATA;
                            end
                        end else begin
                            tx_valid    <= 1'b1;
                            tx_data     <= SFREC_DLE;
                            frame_done  <= 1'b1;
                            rep_count   <= 4'h0;
                            first_err_r <= SFREC_EV_NONE;
                            state_r     <= S_IDLE;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    setup_code_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_IDLE && rx_valid && !rx_fault
         && rx_data != SFREC_NAK && rx_data != SFREC_STX)
        |=> ev_valid && ev_number == SFREC_EV_SETUP)
        else $error("idle stray code not reported");

    idle_nak_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_IDLE && rx_valid && !rx_fault
         && rx_data == SFREC_NAK && !partner_startup)
        |=> !ev_valid && !tx_valid)
        else $error("idle nak not ignored");

    power_up_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_IDLE && rx_valid && !rx_fault && partner_startup
         && rx_data != SFREC_STX)
        |=> ev_valid && ev_number == SFREC_EV_SETUP)
        else $error("power up code not reported");

    event_class_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        ev_valid |-> ev_class == SFREC_CLASS_RX)
        else $error("event class wrong");

    idle_fault_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_IDLE && rx_valid && rx_fault)
        |=> ev_valid && ev_number == SFREC_EV_TXERR)
        else $error("idle fault not reported");

    nak_retry_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (tx_valid && tx_data == SFREC_NAK)
        |-> state_r == S_IDLE && rep_count != 4'h0)
        else $error("nak without retry count");

    first_rep_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (tx_valid && tx_data == SFREC_NAK && rep_count == 4'h1)
        |-> ev_valid && ev_number == SFREC_EV_REPEAT)
        else $error("first repetition not logged");

    give_up_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (ch_run && rep_count >= rep_max
         && (ch_to || (rx_valid && rx_fault)))
        |=> ev_valid && ev_number != SFREC_EV_REPEAT && !tx_valid
            && rep_count == 4'h0)
        else $error("retry limit not reported");

    esc_logic_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_ESC && rx_valid && !rx_fault && !ch_to
         && rx_data != SFREC_DLE && rx_data != SFREC_ETX)
        |=> state_r == S_IDLE)
        else $error("bad escape not caught");

    char_delay_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (ch_run && ch_to)
        |=> state_r == S_IDLE && (tx_valid || ev_valid))
        else $error("character delay not caught");

    bcc_check_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_BCC && rx_valid && !rx_fault && !ch_to
         && rx_data != bcc_r)
        |=> state_r == S_IDLE && !frame_done
            && ((tx_valid && tx_data == SFREC_NAK) || ev_valid))
        else $error("bcc mismatch accepted");

    buf_wait_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_WBUF && buf_to && !rx_valid && !buf_free)
        |=> ev_valid && ev_number == SFREC_EV_NOBUF && state_r == S_IDLE)
        else $error("buffer wait not reported");

    early_code_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (state_r == S_WBUF && rx_valid)
        |=> ev_valid && ev_number == SFREC_EV_SETUP)
        else $error("early code not flagged");

    ack_first_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        (tx_valid && tx_data == SFREC_DLE && state_r == S_DATA)
        |-> $past(state_r) != S_DATA)
        else $error("ack outside setup");

    retry_drop_a: assert property (
        @(posedge clk) disable iff (!rst_n_r)
        $rose(rep_count != 4'h0) |-> state_r == S_IDLE)
        else $error("partial frame kept");
endmodule : sfrec_checker
`default_nettype wire

// File: verification/sfrec_partner.sv
`timescale 1ns/100ps
`default_nettype none
module sfrec_partner (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_fault
);
    import sfrec_pkg::*;
    int ack_cnt = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_fault = 1'b0;
    end
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_data === SFREC_DLE) begin
            ack_cnt <= ack_cnt + 1;
        end
    end
    task automatic put(input logic [7:0] c, input logic f);
        rx_valid <= 1'b1;
        rx_data  <= c;
        rx_fault <= f;
        @(posedge clk);
    endtask : put
    task automatic rest();
        rx_valid <= 1'b0;
        rx_fault <= 1'b0;
        rx_data  <= ~rx_data; // idle line never shows a stale char
        @(posedge clk);
    endtask : rest
    task automatic open_link(output logic ok);
        int a0;
        a0 = ack_cnt;
        put(SFREC_STX, 1'b0);
        rest();
        ok = 1'b0;
        for (int n = 0; n < 8 && !ok; n++) begin // hold off until ack, for at most 8 cycles
            @(negedge clk);
            ok = (ack_cnt != a0);
        end
        @(posedge clk);
    endtask : open_link
endmodule : sfrec_partner
`default_nettype wire

// File: verification/serial_frame_receive_error_checker_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_frame_receive_error_checker_tb;
    import sfrec_pkg::*;
    localparam int CHD = 20;
    localparam int BWT = 30;
    logic       clk, rstn, bcc_en, buf_free, partner_startup, ok;
    logic       rx_valid, rx_fault, tx_valid, ev_valid, frame_done;
    logic [7:0] rx_data, tx_data, ev_class, ev_number, last_ev, last_tx;
    logic [3:0] rep_count;
    int         fail_count, check_count, nak_cnt, done_cnt, cyc;
    sfrec_checker #(.CHDLY_CYC(CHD), .BUFWT_CYC(BWT), .MAX_REP(6)) u_dut (
        .clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_fault(rx_fault), .bcc_en(bcc_en), .buf_free(buf_free),
        .partner_startup(partner_startup), .tx_valid(tx_valid),
        .tx_data(tx_data), .ev_valid(ev_valid), .ev_class(ev_class),
        .ev_number(ev_number), .frame_done(frame_done),
        .rep_count(rep_count));
    sfrec_partner u_prt (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_fault(rx_fault));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk8
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ev_valid === 1'b1) last_ev <= ev_number;
        if (ev_valid === 1'b1) chk8(ev_class, SFREC_CLASS_RX);
        if (tx_valid === 1'b1) last_tx <= tx_data;
        if (tx_valid === 1'b1 && tx_data === SFREC_NAK) nak_cnt <= nak_cnt + 1;
        if (frame_done === 1'b1) done_cnt <= done_cnt + 1;
        if (cyc == 3000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn    <= 1'b1;
        last_ev <= SFREC_EV_NONE;
        nak_cnt <= 0;
        repeat (4) @(posedge clk);
    endtask : do_reset
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle
    task automatic link();
        u_prt.open_link(ok);
        chk8({7'h0, ok}, 8'h01);
    endtask : link
    // first character in the top byte used; n characters are sent
    task automatic body(input logic [39:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) u_prt.put(w[8*i +: 8], 1'b0);
        u_prt.rest();
        settle(2);
    endtask : body
    task automatic t_good_bcc();
        link();
        body({8'h41, SFREC_DLE, SFREC_DLE, SFREC_DLE, SFREC_ETX}, 5);
        chk8(8'(done_cnt), 8'h01);
        bcc_en <= 1'b1;
        link();
        body({8'h00, 8'h41, SFREC_DLE, SFREC_ETX, 8'h52}, 4);
        chk8(8'(done_cnt), 8'h02);
        link();
        body({8'h00, 8'h41, SFREC_DLE, SFREC_ETX, 8'h00}, 4);
        chk8(last_tx, SFREC_NAK);
        chk8(last_ev, SFREC_EV_REPEAT);
        bcc_en <= 1'b0;
    endtask : t_good_bcc
    task automatic t_idle();
        body({32'h0, 8'h41}, 1);
        chk8(last_ev, SFREC_EV_SETUP);
        last_ev <= SFREC_EV_NONE;
        body({32'h0, SFREC_NAK}, 1);
        chk8(last_ev, SFREC_EV_NONE);
        partner_startup <= 1'b1;
        body({32'h0, 8'hff}, 1);
        chk8(last_ev, SFREC_EV_SETUP);
        last_ev <= SFREC_EV_NONE;
        body({32'h0, SFREC_NAK}, 1); // nak is undefined during power up
        chk8(last_ev, SFREC_EV_SETUP);
        partner_startup <= 1'b0;
        u_prt.put(8'h41, 1'b1);
        u_prt.rest();
        settle(2);
        chk8(last_ev, SFREC_EV_TXERR);
        buf_free <= 1'b0; // park in buffer wait so no ack goes out
        body({24'h0, SFREC_STX, 8'h41}, 2);
        chk8(last_ev, SFREC_EV_SETUP);
        buf_free <= 1'b1;
    endtask : t_idle
    task automatic t_timers();
        link();
        settle(CHD + 4);
        chk8(last_tx, SFREC_NAK);
        chk8({4'h0, rep_count}, 8'h01);
        link();
        body({32'h0, 8'h41}, 1);
        settle(CHD + 4);
        chk8({4'h0, rep_count}, 8'h02);
        do_reset();
        buf_free <= 1'b0;
        body({32'h0, SFREC_STX}, 1);
        settle(BWT + 4);
        chk8(last_ev, SFREC_EV_NOBUF);
        buf_free <= 1'b1;
    endtask : t_timers
    task automatic t_retry();
        for (int i = 0; i < 7; i++) begin
            link();
            u_prt.put(SFREC_DLE, 1'b0);
            u_prt.put(8'h41, i != 0); // fault data char after the first try
            u_prt.rest();
            settle(2);
            if (i == 0) chk8({4'h0, rep_count}, 8'h01);
        end
        chk8(last_ev, SFREC_EV_LOGIC);
        chk8({4'h0, rep_count}, 8'h00);
        chk8(8'(nak_cnt), 8'h06);
    endtask : t_retry
    initial begin
        rstn = 1'b0;
        bcc_en = 1'b0;
        buf_free = 1'b1;
        partner_startup = 1'b0;
        fail_count = 0;
        check_count = 0;
        nak_cnt = 0;
        done_cnt = 0;
        cyc = 0;
        last_ev = SFREC_EV_NONE;
        last_tx = 8'h00;
        @(posedge clk);
        do_reset();
        t_good_bcc();
        do_reset();
        t_idle();
        do_reset();
        t_timers();
        do_reset();
        t_retry();
        complete_run();
    end
endmodule : serial_frame_receive_error_checker_tb
`default_nettype wire
